// ### core/aphm_map.vh
`ifndef APHM_MAP_VH
`define APHM_MAP_VH
// ************************************************************
// power level limits
// ************************************************************
`define APHM_LVL_MIN      8'h01
`define APHM_LVL_MAX      8'hfe
// ************************************************************
// identify word numbers and bit positions
// ************************************************************
`define APHM_ID_WSUP      8'd83
`define APHM_ID_WEN       8'd86
`define APHM_ID_WLVL      8'd96
`define APHM_ID_BIT       3
// ************************************************************
// recovery times in ms and in cycles at 100 MHz
// ************************************************************
`define APHM_CLK_KHZ      100000
`define APHM_AIDLE_MS     20
`define APHM_LPIDLE_MS    300
`define APHM_AIDLE_CYC    (`APHM_AIDLE_MS * `APHM_CLK_KHZ)
`define APHM_LPIDLE_CYC   (`APHM_LPIDLE_MS * `APHM_CLK_KHZ)
// ************************************************************
// threshold range
// ************************************************************
`define APHM_THR_MIN      8'd1
`define APHM_THR_MAX      8'd253
// ************************************************************
// power states
// ************************************************************
`define APHM_ST_ACTIVE    3'h0
`define APHM_ST_PIDLE     3'h1
`define APHM_ST_AIDLE     3'h2
`define APHM_ST_LPIDLE    3'h3
`define APHM_ST_STANDBY   3'h4
`define APHM_ST_SLEEP     3'h5
`define APHM_ST_WAKE      3'h6
`endif

// ### core/aphm_hist.v
`timescale 1ns/1ps
// ************************************************************
// interval histogram: one counter per bin, registered read
// ************************************************************
module aphm_hist #(
	parameter BINS = 8,
	parameter AW   = 3,
	parameter CW   = 8
) (
	// clock and reset
	input  wire          core_clk,
	input  wire          rst_n,
	// bump one bin
	input  wire          inc_en,
	input  wire [AW-1:0] inc_bin,
	// read port
	input  wire [AW-1:0] rd_bin,
	output reg  [CW-1:0] rd_data
);
	reg [CW-1:0] mem [0:BINS-1];
	integer i;
	reg sat;

	// halve all bins when one saturates so old history fades
	always @* begin
		sat = inc_en && (mem[inc_bin] == {CW{1'b1}});
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (i = 0; i < BINS; i = i + 1)
				mem[i] <= {CW{1'b0}};
			rd_data <= {CW{1'b0}};
		end else begin
			for (i = 0; i < BINS; i = i + 1) begin
				if (sat)
					mem[i] <= mem[i] >> 1;
				else if (inc_en && inc_bin == i[AW-1:0])
					mem[i] <= mem[i] + {{(CW-1){1'b0}}, 1'b1};
			end
			rd_data <= mem[rd_bin];
		end
	end
endmodule

// ### core/aphm_top.v
`timescale 1ns/1ps
`include "aphm_map.vh"
// What this block does
// - level 01h is lowest power, FEh is highest performance
// - enable subcommand turns feature on with level; disable turns it off
// - standby on timer expiry or on algorithm decision, whichever first
// - identify word 83 bit 3 reports feature supported
// - identify word 86 bit 3 follows the enable state
// - identify word 96 low byte holds current level while enabled
// - after a command the device enters performance idle
// - active idle parks head, recovers in about 20 ms
// - low-power idle unloads heads, spindle on, recovers in about 300 ms
// - intervals between commands are measured into a distribution
// - best-saving candidate whose predicted delay is under level limit
// - selected bin plus one used for low-power idle, plus two for standby entry
// - self-monitoring is off from reset until the host enables it
// - thresholds are fixed 1..253 and the host cannot change them
// - negative status when any value is at or below its threshold
// - with autosave on, save attributes on standby-immediate or sleep
// - save attributes in the same cycle as a timer-driven move from idle to standby
module aphm_top #(
	parameter NATTR    = 4,
	parameter BINS     = 8,
	parameter TICK_DIV = 100000,
	parameter AIDLE_CYC  = `APHM_AIDLE_CYC,
	parameter LPIDLE_CYC = `APHM_LPIDLE_CYC,
	parameter [8*NATTR-1:0] THRESH = {NATTR{8'd50}}
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             rst_n,
	// decoded host commands, one-cycle pulses
	input  wire             cmd_start,
	input  wire             cmd_done,
	input  wire             cmd_apm_on,
	input  wire [7:0]       cmd_apm_level,
	input  wire             cmd_apm_off,
	input  wire             cmd_smart_on,
	input  wire             cmd_smart_off,
	input  wire             cmd_autosave_on,
	input  wire             cmd_autosave_off,
	input  wire             cmd_stby_imm,
	input  wire             cmd_sleep,
	input  wire             stby_timer_exp,
	// attribute values from the monitoring logic
	input  wire [8*NATTR-1:0] attr_values,
	// identify word read
	input  wire [7:0]       id_word_sel,
	output reg  [15:0]      id_word_data,
	// status and actions
	output reg  [2:0]       power_state,
	output reg              cmd_ready,
	output reg              apm_enabled,
	output reg  [7:0]       apm_level,
	output reg              smart_enabled,
	output reg              autosave_enabled,
	output reg              status_negative,
	output reg              attr_save
);
	localparam AW = 3;
	localparam TW = 8;
	localparam [TW-1:0] TMAX = {TW{1'b1}};
	localparam [AW-1:0] LAST = BINS[AW-1:0] - 3'h1;

	// ************************************************************
	// helpers
	// ************************************************************
	function [AW-1:0] bin_of;
		input [TW-1:0] t;
		integer k;
		begin
			bin_of = {AW{1'b0}};
			for (k = 1; k < BINS; k = k + 1)
				if (t >= (8'd1 << k))
					bin_of = k[AW-1:0];
		end
	endfunction

	function [7:0] clip_thr;
		input [7:0] t;
		begin
			if (t < `APHM_THR_MIN)
				clip_thr = `APHM_THR_MIN;
			else if (t > `APHM_THR_MAX)
				clip_thr = `APHM_THR_MAX;
			else
				clip_thr = t;
		end
	endfunction

	// ************************************************************
	// millisecond tick divider
	// ************************************************************
	reg [16:0] div_reg;
	reg        tick;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 17'h0;
			tick    <= 1'b0;
		end else if (div_reg == TICK_DIV - 1) begin
			div_reg <= 17'h0;
			tick    <= 1'b1;
		end else begin
			div_reg <= div_reg + 17'h1;
			tick    <= 1'b0;
		end
	end

	// ************************************************************
	// feature enables
	// ************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			apm_enabled      <= 1'b0;
			apm_level        <= `APHM_LVL_MAX;
			smart_enabled    <= 1'b0;
			autosave_enabled <= 1'b0;
		end else begin
			if (cmd_apm_on) begin
				apm_enabled <= 1'b1;
				// out-of-range levels are clamped into 01h..FEh
				if (cmd_apm_level < `APHM_LVL_MIN)
					apm_level <= `APHM_LVL_MIN;
				else if (cmd_apm_level > `APHM_LVL_MAX)
					apm_level <= `APHM_LVL_MAX;
				else
					apm_level <= cmd_apm_level;
			end else if (cmd_apm_off)
				apm_enabled <= 1'b0;
			if (cmd_smart_on)
				smart_enabled <= 1'b1;
			else if (cmd_smart_off)
				smart_enabled <= 1'b0;
			if (cmd_autosave_on)
				autosave_enabled <= 1'b1;
			else if (cmd_autosave_off)
				autosave_enabled <= 1'b0;
		end
	end

	// ************************************************************
	// interval measurement
	// ************************************************************
	reg  [TW-1:0] gap_reg;
	reg           gap_run;
	wire [TW-1:0] gap_sat = (gap_reg == TMAX) ? TMAX : gap_reg + 8'h1;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg <= {TW{1'b0}};
			gap_run <= 1'b0;
		end else if (cmd_start) begin
			gap_reg <= {TW{1'b0}};
			gap_run <= 1'b0;
		end else if (cmd_done) begin
			gap_run <= 1'b1;
		end else if (gap_run && tick) begin
			gap_reg <= gap_sat;
		end
	end

	// ************************************************************
	// candidate evaluation walk
	// ************************************************************
	// each bin b stands for idle gaps near 2^b ms; a candidate timeout at
	// bin c saves energy on gaps beyond c and pays recovery on them
	reg  [AW-1:0] walk_reg;
	reg           walking;
	wire [TW-1:0] hist_q;
	reg  [TW-1:0] hist_prev;
	reg  [15:0]   long_cnt;
	reg  [15:0]   total_cnt;
	reg  [AW-1:0] best_bin;
	reg  [AW-1:0] sel_bin;
	reg  [15:0]   delay_lim;

	aphm_hist #(
		.BINS(BINS),
		.AW  (AW),
		.CW  (TW)
	) u_hist (
		.core_clk(core_clk),
		.rst_n   (rst_n),
		.inc_en  (cmd_start && gap_run),
		.inc_bin (bin_of(gap_reg)),
		.rd_bin  (walk_reg),
		.rd_data (hist_q)
	);

	// higher level allows less predicted delay for better response
	always @* begin
		delay_lim = {8'h0, ~apm_level} << 4;
	end

	reg [AW-1:0] walk_d;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			walk_reg  <= {AW{1'b0}};
			walk_d    <= {AW{1'b0}};
			walking   <= 1'b0;
			hist_prev <= {TW{1'b0}};
			long_cnt  <= 16'h0;
			total_cnt <= 16'h0;
			best_bin  <= LAST;
			sel_bin   <= LAST;
		end else if (tick && !walking) begin
			walk_reg  <= LAST;
			walk_d    <= LAST;
			walking   <= 1'b1;
			long_cnt  <= 16'h0;
			total_cnt <= 16'h0;
			best_bin  <= LAST;
		end else if (walking) begin
			// walk from longest bin down, accumulating gaps above candidate
			hist_prev <= hist_q;
			walk_d    <= walk_reg;
			if (walk_reg != walk_d || walk_reg == LAST) begin
				long_cnt  <= long_cnt + {8'h0, hist_q};
				total_cnt <= total_cnt + {8'h0, hist_q};
				// delay expectation ~ wakes per history; keep shortest
				// candidate whose wake count fits the level limit
				if ((long_cnt + {8'h0, hist_q}) <= delay_lim)
					best_bin <= walk_reg;
			end
			if (walk_reg == {AW{1'b0}}) begin
				walking <= 1'b0;
				sel_bin <= best_bin;
			end else
				walk_reg <= walk_reg - 3'h1;
		end
	end

	// ************************************************************
	// power state machine
	// ************************************************************
	localparam [2:0] ST_ACTIVE  = `APHM_ST_ACTIVE;
	localparam [2:0] ST_PIDLE   = `APHM_ST_PIDLE;
	localparam [2:0] ST_AIDLE   = `APHM_ST_AIDLE;
	localparam [2:0] ST_LPIDLE  = `APHM_ST_LPIDLE;
	localparam [2:0] ST_STANDBY = `APHM_ST_STANDBY;
	localparam [2:0] ST_SLEEP   = `APHM_ST_SLEEP;
	localparam [2:0] ST_WAKE    = `APHM_ST_WAKE;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg  [24:0] wake_cnt;
	wire [AW-1:0] lp_bin = (sel_bin == LAST) ? LAST : sel_bin + 3'h1;
	wire [AW-1:0] sb_bin = (lp_bin == LAST) ? LAST : lp_bin + 3'h1;
	// full-range bin means no candidate fits; stay in performance idle
	wire go_aidle = apm_enabled && sel_bin != LAST &&
		bin_of(gap_reg) >= sel_bin;
	wire go_lp = apm_enabled && lp_bin != LAST &&
		bin_of(gap_reg) >= lp_bin;
	wire go_sb = apm_enabled && sb_bin != LAST &&
		bin_of(gap_reg) >= sb_bin;
	wire idle_st = state_reg == ST_PIDLE || state_reg == ST_AIDLE ||
		state_reg == ST_LPIDLE;

	always @* begin
		state_next = state_reg;
		case (state_reg)
		ST_ACTIVE: begin
			if (cmd_done)
				state_next = ST_PIDLE;
		end
		ST_PIDLE, ST_AIDLE, ST_LPIDLE: begin
			if (cmd_start)
				state_next = (state_reg == ST_PIDLE) ? ST_ACTIVE : ST_WAKE;
			else if (stby_timer_exp || go_sb)
				state_next = ST_STANDBY;
			else if (state_reg != ST_LPIDLE && go_lp)
				state_next = ST_LPIDLE;
			else if (state_reg == ST_PIDLE && go_aidle)
				state_next = ST_AIDLE;
		end
		ST_STANDBY: begin
			if (cmd_start)
				state_next = ST_WAKE;
		end
		ST_WAKE: begin
			if (wake_cnt == 25'h0)
				state_next = ST_ACTIVE;
		end
		ST_SLEEP: begin
			state_next = ST_SLEEP;
		end
		default: begin
			state_next = ST_ACTIVE;
		end
		endcase
		// only a reset leaves sleep, so late power commands are dropped
		if (state_reg != ST_SLEEP) begin
			if (cmd_sleep)
				state_next = ST_SLEEP;
			else if (cmd_stby_imm)
				state_next = ST_STANDBY;
		end
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_ACTIVE;
			wake_cnt  <= 25'h0;
		end else begin
			state_reg <= state_next;
			if (state_next == ST_WAKE && state_reg != ST_WAKE)
				wake_cnt <= (state_reg == ST_AIDLE) ?
					AIDLE_CYC[24:0] - 25'h1 :
					LPIDLE_CYC[24:0] - 25'h1;
			else if (wake_cnt != 25'h0)
				wake_cnt <= wake_cnt - 25'h1;
		end
	end

	// ************************************************************
	// health status and attribute save
	// ************************************************************
	reg neg_next;
	integer a;
	always @* begin
		neg_next = 1'b0;
		for (a = 0; a < NATTR; a = a + 1)
			// thresholds are build-time constants, no write path exists
			if (attr_values[8*a +: 8] <= clip_thr(THRESH[8*a +: 8]))
				neg_next = 1'b1;
	end

	wire save_cmd = smart_enabled && autosave_enabled &&
		(cmd_stby_imm || cmd_sleep);
	wire save_tmr = smart_enabled && idle_st && state_next == ST_STANDBY &&
		!cmd_stby_imm && !cmd_sleep;

	// ************************************************************
	// registered outputs
	// ************************************************************
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_negative <= 1'b0;
			attr_save       <= 1'b0;
			power_state     <= ST_ACTIVE;
			cmd_ready       <= 1'b1;
			id_word_data    <= 16'h0;
		end else begin
			status_negative <= smart_enabled && neg_next;
			attr_save       <= save_cmd || save_tmr;
			power_state     <= state_next;
			cmd_ready       <= state_next != ST_WAKE &&
				state_next != ST_SLEEP;
			if (id_word_sel == `APHM_ID_WSUP)
				id_word_data <= 16'h1 << `APHM_ID_BIT;
			else if (id_word_sel == `APHM_ID_WEN)
				id_word_data <= {15'h0, apm_enabled} << `APHM_ID_BIT;
			else if (id_word_sel == `APHM_ID_WLVL)
				id_word_data <= apm_enabled ?
					{8'h0, apm_level} : 16'h0;
			else
				id_word_data <= 16'h0;
		end
	end
endmodule

// ### tb/aphm_properties.sv
`timescale 1ns/1ps
// ************************************************************
// power and health checks on the top ports
// ************************************************************
module aphm_properties #(
	parameter NATTR = 4,
	parameter [8*NATTR-1:0] THRESH = {NATTR{8'd50}}
) (
	// clock and reset
	input wire               core_clk,
	input wire               rst_n,
	// commands
	input wire               cmd_start,
	input wire               cmd_done,
	input wire               cmd_apm_on,
	input wire [7:0]         cmd_apm_level,
	input wire               cmd_apm_off,
	input wire               cmd_stby_imm,
	input wire               cmd_sleep,
	input wire               stby_timer_exp,
	input wire [8*NATTR-1:0] attr_values,
	input wire [7:0]         id_word_sel,
	// status
	input wire [15:0]        id_word_data,
	input wire [2:0]         power_state,
	input wire               cmd_ready,
	input wire               apm_enabled,
	input wire [7:0]         apm_level,
	input wire               smart_enabled,
	input wire               autosave_enabled,
	input wire               status_negative,
	input wire               attr_save
);
	reg     low;
	integer i;
	wire    aw = power_state != 3'h5;
	always @* begin
		low = 1'b0;
		for (i = 0; i < NATTR; i = i + 1)
			if (attr_values[8*i+:8] <= THRESH[8*i+:8])
				low = 1'b1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_level_taken: assert property (
		cmd_apm_on && aw && |cmd_apm_level && ~&cmd_apm_level |=>
		apm_enabled && apm_level == $past(cmd_apm_level))
		else $error("level not taken");
	a_level_clamp: assert property (
		cmd_apm_on && aw && (&cmd_apm_level || ~|cmd_apm_level) |=>
		apm_level == (&$past(cmd_apm_level) ? 8'hfe : 8'h01))
		else $error("level not clamped");
	a_apm_off: assert property (
		cmd_apm_off && !cmd_apm_on && aw |=> !apm_enabled)
		else $error("feature stays on");
	a_word_sup: assert property (
		id_word_sel == 8'd83 |=> id_word_data[3])
		else $error("support bit clear");
	a_word_en: assert property (
		id_word_sel == 8'd86 ##1 $stable(apm_enabled) |->
		id_word_data[3] == apm_enabled) else $error("enable bit wrong");
	a_word_lvl: assert property (
		id_word_sel == 8'd96 && apm_enabled ##1 apm_enabled &&
		$stable(apm_level) |-> id_word_data[7:0] == apm_level)
		else $error("level word wrong");
	a_health_cmp: assert property (
		smart_enabled && $stable(attr_values) ##1 smart_enabled &&
		$stable(attr_values) |-> status_negative == low)
		else $error("status wrong");
	a_health_off: assert property (
		!smart_enabled && !$past(smart_enabled) |-> !status_negative)
		else $error("status while off");
	a_sleep_save: assert property (
		cmd_sleep && aw && smart_enabled && autosave_enabled |=>
		attr_save && power_state == 3'h5 && !cmd_ready)
		else $error("no save on sleep");
	a_wake_aidle: assert property (
		power_state == 3'h2 && cmd_start |=>
		(power_state == 3'h6) [*8] ##[1:30] power_state == 3'h0)
		else $error("bad wake time");
	a_perf_idle: assert property (
		cmd_done && power_state == 3'h0 && !cmd_start && !cmd_sleep &&
		!cmd_stby_imm && !stby_timer_exp |=> power_state == 3'h1)
		else $error("no perf idle");
	a_timer_stby: assert property (
		stby_timer_exp && power_state inside {3'h1, 3'h2, 3'h3} &&
		!cmd_start && !cmd_sleep |=> power_state == 3'h4)
		else $error("no standby");
	c_save: cover property (attr_save);
	c_wake: cover property (power_state == 3'h2 && cmd_start);
	c_neg: cover property (status_negative);
endmodule

// ### tb/aphm_host.sv
`timescale 1ns/1ps
// ************************************************************
// host side: decoded task-file commands
// ************************************************************
module aphm_host (
	// clock
	input  wire        core_clk,
	// strobes and level
	output reg  [10:0] cmd,
	output reg  [7:0]  lvl
);
	initial begin
		cmd = 11'h000;
		lvl = 8'h00;
	end
	// one-cycle strobes; level is not held valid after the strobe
	task send(input [10:0] c, input [7:0] l);
		begin
			@(posedge core_clk);
			cmd <= c;
			lvl <= l;
			@(posedge core_clk);
			cmd <= 11'h000;
			lvl <= ~l;
		end
	endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
// ************************************************************
// bench top
// ************************************************************
module tb_top;
	localparam        NATTR  = 4;
	localparam [31:0] THRESH = {4{8'd50}};
	localparam [39:0] LV     = 40'h000180feff;
	reg         core_clk;
	reg         rst_n;
	reg  [31:0] attr;
	reg  [7:0]  sel;
	reg  [15:0] rdata;
	wire [10:0] cmd;
	wire [7:0]  lvl;
	wire [15:0] id_word_data;
	wire [2:0]  ps;
	wire        rdy;
	wire        apm_en;
	wire [7:0]  apm_lv;
	wire        sm_en;
	wire        as_en;
	wire        neg;
	wire        save;
	integer     error_cnt;
	integer     num_checks;
	integer     i;
	aphm_host i_host (.core_clk(core_clk), .cmd(cmd), .lvl(lvl));
	// short counts keep the run small
	aphm_top #(.NATTR(NATTR), .TICK_DIV(10), .AIDLE_CYC(20),
		.LPIDLE_CYC(30), .THRESH(THRESH)) i_dut (
		.core_clk(core_clk), .rst_n(rst_n),
		.cmd_start(cmd[0]), .cmd_done(cmd[1]),
		.cmd_apm_on(cmd[2]), .cmd_apm_level(lvl),
		.cmd_apm_off(cmd[3]), .cmd_smart_on(cmd[4]),
		.cmd_smart_off(cmd[5]), .cmd_autosave_on(cmd[6]),
		.cmd_autosave_off(cmd[7]), .cmd_stby_imm(cmd[8]),
		.cmd_sleep(cmd[9]), .stby_timer_exp(cmd[10]),
		.attr_values(attr), .id_word_sel(sel),
		.id_word_data(id_word_data), .power_state(ps),
		.cmd_ready(rdy), .apm_enabled(apm_en), .apm_level(apm_lv),
		.smart_enabled(sm_en), .autosave_enabled(as_en),
		.status_negative(neg), .attr_save(save));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task rd(input [7:0] w);
		begin
			@(posedge core_clk);
			sel <= w;
			@(posedge core_clk);
			@(posedge core_clk);
			#1 rdata = id_word_data;
		end
	endtask
	task test_done;
		begin
			if (error_cnt == 0 && num_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task t_reset;
		begin
			chk(sm_en, 0);
			chk(ps, 0);
			chk(rdy, 1);
			rd(8'd83);
			chk(rdata[3], 1);
			rd(8'd86);
			chk(rdata[3], 0);
		end
	endtask
	task t_apm;
		reg [7:0] l;
		reg [7:0] e;
		begin
			for (i = 4; i >= 0; i = i - 1) begin
				l = LV[8*i+:8];
				e = (l == 8'h00) ? 8'h01 : (l == 8'hff) ? 8'hfe : l;
				i_host.send(11'h004, l);
				#1 chk(apm_lv, e);
				rd(8'd96);
				chk(rdata[7:0], e);
				rd(8'd86);
				chk(rdata[3], 1);
			end
			i_host.send(11'h008, 8'h00);
			#1 chk(apm_en, 0);
			rd(8'd86);
			chk(rdata[3], 0);
			i_host.send(11'h00c, 8'h40);
			#1 chk(apm_en, 1);
		end
	endtask
	task set_attr(input [31:0] a, input exp);
		begin
			@(posedge core_clk);
			attr <= a;
			repeat (3) @(posedge core_clk);
			#1 chk(neg, exp);
		end
	endtask
	task t_smart;
		begin
			i_host.send(11'h010, 8'h00);
			#1 chk(sm_en, 1);
			set_attr(32'hc8c833c8, 0);
			set_attr(32'hc8c832c8, 1);
			set_attr(32'hc8c8c8c8, 0);
			set_attr(32'h32c8c8c8, 1);
			i_host.send(11'h020, 8'h00);
			repeat (2) @(posedge core_clk);
			#1 chk(neg, 0);
			set_attr(32'hc8c8c8c8, 0);
		end
	endtask
	task t_idle;
		begin
			i_host.send(11'h004, 8'h01);
			i_host.send(11'h001, 8'h00);
			i_host.send(11'h002, 8'h00);
			#1 chk(ps, 1);
			for (i = 0; i < 20000 && ps !== 3'h2; i = i + 1)
				@(posedge core_clk) #1;
			chk(ps, 2);
			i_host.send(11'h001, 8'h00);
			#1 chk(ps, 6);
			chk(rdy, 0);
			repeat (25) @(posedge core_clk);
			#1 chk(ps, 0);
		end
	endtask
	task t_stby;
		begin
			i_host.send(11'h050, 8'h00);
			i_host.send(11'h002, 8'h00);
			i_host.send(11'h400, 8'h00);
			#1 chk(ps, 4);
			chk(save, 1);
			i_host.send(11'h001, 8'h00);
			repeat (40) @(posedge core_clk);
			i_host.send(11'h100, 8'h00);
			#1 chk(ps, 4);
			chk(save, 1);
		end
	endtask
	task t_sleep;
		begin
			i_host.send(11'h200, 8'h00);
			#1 chk(save, 1);
			chk(ps, 5);
			chk(rdy, 0);
			i_host.send(11'h001, 8'h00);
			#1 chk(ps, 5);
			@(posedge core_clk);
			rst_n <= 1'b0;
			repeat (4) @(posedge core_clk);
			rst_n <= 1'b1;
			#1 chk(ps, 0);
			chk(sm_en, 0);
			chk(apm_en, 0);
		end
	endtask
	initial begin
		rst_n = 1'b0;
		attr = 32'hc8c8c8c8;
		sel = 8'h00;
		error_cnt = 0;
		num_checks = 0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_apm;
		t_smart;
		t_idle;
		t_stby;
		t_sleep;
		test_done;
	end
	initial begin
		#400000;
		error_cnt = error_cnt + 1;
		test_done;
	end
endmodule
bind aphm_top aphm_properties #(.NATTR(NATTR), .THRESH(THRESH)) i_prop (
	.core_clk, .rst_n, .cmd_start, .cmd_done, .cmd_apm_on,
	.cmd_apm_level, .cmd_apm_off, .cmd_stby_imm, .cmd_sleep,
	.stby_timer_exp, .attr_values, .id_word_sel, .id_word_data,
	.power_state, .cmd_ready, .apm_enabled, .apm_level,
	.smart_enabled, .autosave_enabled, .status_negative, .attr_save);
